// [inc/fine_edge_pkg.sv]
package fine_edge_pkg;

  localparam int COUNT_W = 16;
  localparam int STEP_W = 8;
  localparam int WORD_W = 32;

  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [COUNT_W-1:0] PERIOD_MAX = 16'hffff;
  localparam logic [STEP_W-1:0] STEP_NONE = 8'h00;

  localparam int CLOCK_PERIOD_PS = 8000;

  // One 32-bit write: coarse compare in the upper half, fine extension below
  typedef struct packed {
    logic [COUNT_W-1:0] coarse;
    logic [STEP_W-1:0] fineStep;
    logic [STEP_W-1:0] fineUnused;
  } compare_word_type;

  typedef struct packed {
    logic [COUNT_W-1:0] coarse;
    logic [STEP_W-1:0] fineStep;
  } compare_set_type;

endpackage : fine_edge_pkg

// [design/micro_delay_line.sv]
module micro_delay_line
  import fine_edge_pkg::*;
(
  input wire logic clk, // Time base clock
  input wire logic rst_n, // Async reset, active low
  input wire logic clkEn, // Freezes state while low
  input wire logic coarseLevel, // Level from the coarse compare
  input wire logic [STEP_W-1:0] stepCount, // Fine steps to add
  output logic lineOut, // Registered level to the tap chain
  output logic [STEP_W-1:0] tapSelect, // Tap code, zero is bypass
  output logic bypass // High when no fine delay applies
);

  wire logic noSteps;

  assign noSteps = (stepCount == STEP_NONE);

  // The taps themselves are outside the clocked logic; here the edge and
  // its tap code leave together from one register so they never skew.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lineOut <= 1'b0;
      tapSelect <= STEP_NONE;
      bypass <= 1'b1;
    end
    else if (clkEn)
    begin
      lineOut <= coarseLevel;
      tapSelect <= stepCount;
      bypass <= noSteps;
    end
  end

  zero_bypass_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && stepCount == STEP_NONE |=> bypass && tapSelect == STEP_NONE)
    else $error("zero step count did not bypass the delay");

  tap_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn |=> tapSelect == $past(stepCount) && lineOut == $past(coarseLevel))
    else $error("tap code or level not carried through");

endmodule : micro_delay_line

// [design/fine_edge_compare_extension.sv]
// Notes on behaviour
// - Period lasts period_count clocks; coarse edge falls after compare count clocks.
// - Compare edge is delayed further by the fine step count of delay steps.
// - Step count comes only from the upper byte; low byte is ignored.
// - Coarse and fine values arrive as one 32-bit word, coarse in upper half.
// - Period count may be any value up to 65535 in up-count mode.
// - Fine delay steps are set by an 8-bit field of the extension.
// - With shadowing selected, both values are double buffered until period start.
module fine_edge_compare_extension
  import fine_edge_pkg::*;
(
  input wire logic clk, // Time base clock, 125 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic clkEn, // Freezes all state while low
  input wire logic compareWrite, // One-cycle write strobe
  input wire compare_word_type compareWord, // Coarse and fine values together
  input wire logic [COUNT_W-1:0] periodCount, // Period in clocks
  input wire logic shadowSelect, // High: load at period start
  output logic pwmOut, // Coarse level toward the delay taps
  output logic [STEP_W-1:0] delayTap, // Fine step code for the taps
  output logic fineBypass, // High when no fine delay is added
  output logic periodStart // One-cycle pulse at each period start
);

  logic [COUNT_W-1:0] counter;
  compare_set_type active;
  compare_set_type shadow;
  logic pendingLoad;

  wire logic [COUNT_W-1:0] lastIndex;
  wire logic lastCount;
  wire logic zeroPeriod;
  wire logic atOrPastEnd;
  wire logic wrapNow;
  wire logic [COUNT_W-1:0] next_counter;
  wire compare_set_type written;
  wire logic directWrite;
  wire logic shadowWrite;
  wire logic shadowLoad;
  wire compare_set_type next_active;
  wire logic next_pendingLoad;
  wire logic coarseLevel;

  // A zero period holds the counter at zero instead of wrapping
  assign lastIndex = periodCount - COUNT_ONE;
  assign zeroPeriod = (periodCount == COUNT_ZERO);
  // At or past: a period shrunk below the count wraps at once, not after 65536
  assign atOrPastEnd = (counter >= lastIndex);
  assign lastCount = zeroPeriod || atOrPastEnd;
  assign wrapNow = clkEn && lastCount;
  assign next_counter = lastCount ? COUNT_ZERO : counter + COUNT_ONE;

  // Low byte of the extension is dropped here and never stored
  assign written.coarse = compareWord.coarse;
  assign written.fineStep = compareWord.fineStep;

  assign directWrite = compareWrite && !shadowSelect;
  assign shadowWrite = compareWrite && shadowSelect;
  assign shadowLoad = wrapNow && pendingLoad;

  // A direct write beats a pending shadow load in the same cycle
  assign next_active = directWrite ? written : (shadowLoad ? shadow : active);

  // A new shadow write wins over the clear at period start
  assign next_pendingLoad = shadowWrite || (pendingLoad && !lastCount);

  // Set at count zero, cleared at the compare count
  assign coarseLevel = (counter < active.coarse);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      counter <= COUNT_ZERO;
    else if (clkEn)
      counter <= next_counter;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active <= '0;
      shadow <= '0;
      pendingLoad <= 1'b0;
    end
    else if (clkEn)
    begin
      active <= next_active;
      if (shadowWrite)
        shadow <= written;
      pendingLoad <= next_pendingLoad;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      periodStart <= 1'b0;
    else if (clkEn)
      periodStart <= lastCount;
  end

  micro_delay_line delayStage (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .coarseLevel(coarseLevel),
    .stepCount(active.fineStep),
    .lineOut(pwmOut),
    .tapSelect(delayTap),
    .bypass(fineBypass)
  );

  counter_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    periodCount != COUNT_ZERO |-> counter <= lastIndex || $changed(periodCount))
    else $error("counter ran past the period");

  period_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && counter == lastIndex && periodCount != COUNT_ZERO |=> counter == COUNT_ZERO)
    else $error("counter did not wrap at the period end");

  count_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && !lastCount |=> counter == $past(counter) + COUNT_ONE)
    else $error("counter did not advance by one");

  direct_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && directWrite |=> active.coarse == $past(compareWord.coarse)
      && active.fineStep == $past(compareWord.fineStep))
    else $error("direct write did not load both halves");

  low_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && directWrite ##1 clkEn ##1 1'b1 |-> delayTap == $past(compareWord.fineStep, 2))
    else $error("fine step not taken from the upper byte");

  shadow_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && !compareWrite && !lastCount |=> active == $past(active))
    else $error("active compare changed mid period");

  shadow_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && lastCount && pendingLoad && !directWrite |=> active == $past(shadow)
      && (!pendingLoad || $past(shadowWrite)))
    else $error("shadow value not loaded at period start");

  level_track_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn |=> pwmOut == ($past(counter) < $past(active.coarse)))
    else $error("output level does not follow the compare");

  start_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && lastCount && periodCount != COUNT_ZERO |=> periodStart && counter == COUNT_ZERO)
    else $error("period start pulse misplaced");

  pulse_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    periodStart |-> counter == COUNT_ZERO)
    else $error("period start pulse away from count zero");

  // Shadow path: a write waits in the copy until the wrap
  shadow_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && shadowWrite |=> pendingLoad)
    else $error("shadow write did not arm a period start load");

  shadow_fields_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && shadowWrite |=> shadow.coarse == $past(compareWord.coarse)
      && shadow.fineStep == $past(compareWord.fineStep))
    else $error("shadow copy lost a field of the written word");

  shadow_defer_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && shadowWrite && !lastCount |=> active == $past(active))
    else $error("shadow write reached the active compare early");

  pending_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && pendingLoad && !lastCount |=> pendingLoad)
    else $error("pending load dropped before period start");

  pending_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && lastCount && !shadowWrite |=> !pendingLoad)
    else $error("pending load not cleared at period start");

  // Waveform shape against the counter
  start_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && !lastCount |=> !periodStart)
    else $error("period start pulse away from the wrap");

  start_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && counter == COUNT_ZERO && active.coarse != COUNT_ZERO |=> pwmOut)
    else $error("output not set at count zero");

  compare_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && counter == active.coarse |=> !pwmOut)
    else $error("output not cleared at the compare count");

  max_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    periodCount == PERIOD_MAX |-> counter != PERIOD_MAX)
    else $error("counter reached a value beyond the longest period");

  // Tap code hand-off toward the delay line
  tap_steps_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && active.fineStep != STEP_NONE |=> !fineBypass
      && delayTap == $past(active.fineStep))
    else $error("nonzero step count not passed to the taps");

  tap_bypass_a: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && active.fineStep == STEP_NONE |=> fineBypass && delayTap == STEP_NONE)
    else $error("zero step count still added a fine delay");

  // Clock enable low must leave every register as it was
  freeze_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    !clkEn |=> counter == $past(counter) && periodStart == $past(periodStart))
    else $error("time base moved while frozen");

  freeze_compare_a: assert property (@(posedge clk) disable iff (!rst_n)
    !clkEn |=> active == $past(active) && shadow == $past(shadow)
      && pendingLoad == $past(pendingLoad))
    else $error("compare values moved while frozen");

  freeze_output_a: assert property (@(posedge clk) disable iff (!rst_n)
    !clkEn |=> pwmOut == $past(pwmOut) && delayTap == $past(delayTap)
      && fineBypass == $past(fineBypass))
    else $error("outputs moved while frozen");

endmodule : fine_edge_compare_extension

// [bench/power_stage_model.sv]
module power_stage_model
(
  input wire logic clk, // Time base clock
  input wire logic pwmOut, // Coarse level
  input wire logic periodStart, // Period start pulse
  output logic [31:0] highCycles, // High cycles, last period
  output logic [31:0] periodCycles // Length of last period
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] hc;
  logic [31:0] pc;
  initial
  begin
    hc = 0;
    pc = 0;
  end
  // Window runs from pulse to pulse, so any phase lag still counts every high cycle
  always @(posedge clk)
  begin
    if (periodStart)
    begin
      highCycles <= hc;
      periodCycles <= pc;
      hc <= {31'd0, pwmOut};
      pc <= 1;
    end
    else
    begin
      hc <= hc + {31'd0, pwmOut};
      pc <= pc + 1;
    end
  end
endmodule : power_stage_model

// [bench/fine_edge_compare_extension_tb.sv]
module fine_edge_compare_extension_tb;
  import fine_edge_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstN = 0, cw = 0, shadowSel = 0, en = 1;
  compare_word_type word = '0;
  logic [15:0] per = 16'h0050;
  logic pwmOut, fineBypass, periodStart;
  logic [7:0] delayTap;
  logic [31:0] hi, pc;
  int n_fail = 0, checks_done = 0;
  localparam int STEPS_PER_CLOCK = 10000 / 180; // Worked out once, not per update
  fine_edge_compare_extension u_dut (.clk(clk), .rst_n(rstN), .clkEn(en),
    .compareWrite(cw), .compareWord(word), .periodCount(per), .shadowSelect(shadowSel),
    .pwmOut(pwmOut), .delayTap(delayTap), .fineBypass(fineBypass), .periodStart(periodStart));
  power_stage_model u_stage (.clk(clk), .pwmOut(pwmOut), .periodStart(periodStart),
    .highCycles(hi), .periodCycles(pc));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] w);
    @(posedge clk);
    cw <= 1'b1;
    word <= w;
    @(posedge clk);
    cw <= 1'b0;
  endtask : wr
  // Returns just after the edge that launched the next pulse, read once settled
  task automatic wait_start();
    int i;
    for (i = 0; i < 70000; i++)
    begin
      @(posedge clk);
      #1;
      if (periodStart === 1'b1)
        break;
    end
  endtask : wait_start
  // Stage model latches a period one edge after the pulse that closes it
  task automatic full_period();
    wait_start();
    wait_start();
    @(posedge clk);
    #1;
  endtask : full_period
  task automatic t_host_word();
    int c, f;
    c = (405 * 80) / 1000;
    f = ((405 * 80 % 1000) * STEPS_PER_CLOCK * 256 / 1000 + 384);
    chk({c[15:0], f[15:0]}, 32'h0020_1780);
    wr({c[15:0], f[15:0]});
    full_period();
    chk(hi, 32'd32);
    chk(pc, 32'd80);
    chk({fineBypass, delayTap}, 9'h017);
  endtask : t_host_word
  task automatic t_direct(input logic [31:0] w, input logic [31:0] eh, input logic [8:0] et);
    wr(w);
    full_period();
    chk(hi, eh);
    chk({fineBypass, delayTap}, et);
  endtask : t_direct
  task automatic t_shadow();
    @(posedge clk);
    shadowSel <= 1'b1;
    wait_start();
    wr(32'h0030_4400);
    repeat (2) @(posedge clk);
    #1;
    chk(delayTap, 8'h00);
    wait_start();
    @(posedge clk);
    #1;
    chk(delayTap, 8'h44);
    full_period();
    chk(hi, 32'd48);
    @(posedge clk);
    shadowSel <= 1'b0;
  endtask : t_shadow
  // A strobe while the clock enable is low must leave the compare untouched
  task automatic t_freeze();
    @(posedge clk);
    en <= 1'b0;
    wr(32'h0008_5500);
    @(posedge clk);
    en <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({fineBypass, delayTap}, 9'h044);
  endtask : t_freeze
  // Period raised right after a wrap, so the next window is one whole long period
  task automatic t_max_period();
    wait_start();
    @(posedge clk);
    per <= PERIOD_MAX;
    wait_start();
    @(posedge clk);
    #1;
    chk(pc, 32'd65535);
    chk(hi, 32'd48);
  endtask : t_max_period
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial
  begin
    // Run needs about 67k cycles, nearly all in the longest period
    repeat (90000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rstN <= 1'b1;
    t_host_word();
    t_direct(32'h0020_17ff, 32'd32, 9'h017);
    t_direct(32'h0005_2a00, 32'd5, 9'h02a);
    t_direct(32'h0010_0000, 32'd16, 9'h100);
    t_shadow();
    t_freeze();
    t_max_period();
    end_of_test();
  end
endmodule : fine_edge_compare_extension_tb
